// File: eid_pkg.sv
// Purpose: Shared constants and types for the extended instruction decoder
// Assumes: 16-bit instruction words, 12-bit data addresses, 8-bit data
// Notes: Encodings are the top nibbles/bytes of the added opcodes, except the call, which is a full 16-bit word
package eid_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // ************************************************************
    // Opcode fields
    // ************************************************************
    localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
    localparam logic [7:0] OPC_PTR_SUB = 8'hE9;
    localparam logic [7:0] OPC_PUSH_LIT = 8'hEA;
    localparam logic [7:0] OPC_MOVE_IDX = 8'hEB;
    localparam logic [15:0] OPC_CALL_WORK = 16'h0014;
    localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
    localparam logic [1:0] SEL_FRAME_PTR = 2'h3;
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam int PTR_COUNT = 3;
    // ************************************************************
    // Timing counts in instruction cycles
    // ************************************************************
    localparam int CYC_SHORT = 1;
    localparam int CYC_LONG = 2;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;

    typedef enum logic [3:0]
    {
        EID_NONE,
        EID_PTR_ADD,
        EID_PTR_SUB,
        EID_FRAME_ADD_RET,
        EID_FRAME_SUB_RET,
        EID_CALL_WORK,
        EID_PUSH_LIT,
        EID_MOVE_TO_FILE,
        EID_MOVE_TO_IDX
    } eid_op_type;
endpackage

// File: eid_addr_if.sv
// Purpose: Carries a decoded file operand between decoder and address unit
// Assumes: One operand per instruction cycle
// Notes: Decoder drives the request, address unit answers
`timescale 1ns/1ps
`default_nettype none
interface eid_addr_if;
    import eid_pkg::*;
    logic [7:0] file_field;
    logic access_sel;
    logic ext_on;
    logic [3:0] bank;
    logic [ADDR_W-1:0] frame_ptr;
    logic [ADDR_W-1:0] eff_addr;
    logic indexed;
    modport requester (output file_field, access_sel, ext_on, bank,
        frame_ptr, input eff_addr, indexed);
    modport resolver (input file_field, access_sel, ext_on, bank,
        frame_ptr, output eff_addr, indexed);
endinterface
`default_nettype wire

// File: eid_addr_unit.sv
// Purpose: Forms effective data address of a byte/bit file operand
// Assumes: Combinational, used in the decode cycle before the read
// Notes: Indexed form wraps to the data address width
`timescale 1ns/1ps
`default_nettype none
module eid_addr_unit
    import eid_pkg::*;
(
    eid_addr_if.resolver ab
);
    // ************************************************************
    // Address resolution
    // ************************************************************
    always_comb
    begin
        ab.indexed = ab.ext_on && !ab.access_sel
            && (ab.file_field <= OFFSET_LIMIT);
        if (ab.indexed)
            ab.eff_addr = ab.frame_ptr + {4'h0, ab.file_field};
        else if (ab.access_sel)
            ab.eff_addr = {ab.bank, ab.file_field};
        else if (ab.file_field < ACCESS_SPLIT)
            ab.eff_addr = {4'h0, ab.file_field};
        else
            ab.eff_addr = {ACCESS_HIGH_BANK, ab.file_field};
    end
endmodule
`default_nettype wire

// File: eid_decoder.sv
// Purpose: Decode and execute the extended literal instructions
// Assumes: One instruction word per cycle on instr_i, qualified by valid
// Notes: Data writes and return/call go out as registered requests
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module eid_decoder
    import eid_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ext_set_enable_fuse_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [DATA_W-1:0] working_reg_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    output logic [ADDR_W-1:0] ptr0_o,
    output logic [ADDR_W-1:0] ptr1_o,
    output logic [ADDR_W-1:0] stack_frame_pointer_o,
    output logic [ADDR_W-1:0] file_addr_o,
    output logic file_indexed_o,
    output logic wr_en_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic return_req_o,
    output logic call_req_o,
    output logic [DATA_W-1:0] call_low_o,
    output logic ext_op_o,
    output logic busy_o
);
    typedef enum logic [1:0]
    {
        EID_IDLE,
        EID_SECOND,
        EID_FINISH
    } eid_state_type;

    eid_state_type state_reg;
    eid_op_type op_reg;
    eid_op_type op_next;
    logic [ADDR_W-1:0] ptr_reg [PTR_COUNT];
    eid_addr_if ab ();

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Select 11 folds onto index 2, so exactly three pointers exist
    if (PTR_COUNT != 3)
    begin
        $error("pointer file must hold exactly three pointers");
    end
    // Operand fields and the second move word assume 12-bit addresses
    if (ADDR_W != 12)
    begin
        $error("data address must be 12 bits wide");
    end
    // Push and move carry one data byte per word
    if (DATA_W != 8)
    begin
        $error("data path must be one byte wide");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Frame pointer plus an unsigned offset, wrapped to address width
    function automatic logic [ADDR_W-1:0] frame_offset(
        input logic [ADDR_W-1:0] base, input logic [6:0] off);
        frame_offset = base + {5'h00, off};
    endfunction

    // Select 11 names the frame pointer, which lives at index 2
    function automatic logic [1:0] ptr_index(input logic [1:0] sel);
        ptr_index = (sel == SEL_FRAME_PTR) ? 2'h2 : sel;
    endfunction

    // Both indexed moves share the two-word sequence
    function automatic logic is_move(input eid_op_type op);
        is_move = (op == EID_MOVE_TO_FILE) || (op == EID_MOVE_TO_IDX);
    endfunction

    // ************************************************************
    // Decode of the first word
    // ************************************************************
    always_comb
    begin
        op_next = EID_NONE;
        if (ext_set_enable_fuse_i && instr_valid_i)
        begin
            unique case (instr_i[15:8])
                OPC_PTR_ADD: op_next = (instr_i[7:6] == SEL_FRAME_PTR)
                    ? EID_FRAME_ADD_RET : EID_PTR_ADD;
                OPC_PTR_SUB: op_next = (instr_i[7:6] == SEL_FRAME_PTR)
                    ? EID_FRAME_SUB_RET : EID_PTR_SUB;
                OPC_PUSH_LIT: op_next = EID_PUSH_LIT;
                OPC_MOVE_IDX: op_next = instr_i[7]
                    ? EID_MOVE_TO_IDX : EID_MOVE_TO_FILE;
                default: op_next = (instr_i == OPC_CALL_WORK)
                    ? EID_CALL_WORK : EID_NONE;
            endcase
        end
    end

    // ************************************************************
    // Operand address for base byte/bit instructions
    // ************************************************************
    // Field is the low byte, access bit is bit 8 in every byte/bit form
    assign ab.file_field = instr_i[7:0];
    assign ab.access_sel = instr_i[8];
    assign ab.ext_on = ext_set_enable_fuse_i;
    assign ab.bank = bank_select_reg_i;
    assign ab.frame_ptr = ptr_reg[2];

    eid_addr_unit u_addr (.ab(ab.resolver));

    // Registered so the port stays glitch free; read happens next cycle
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            file_addr_o <= PTR_RESET;
            file_indexed_o <= 1'b0;
        end
        else if (instr_valid_i && state_reg == EID_IDLE)
        begin
            // A move's source is always frame relative, whatever bit 8 says
            if (is_move(op_next))
            begin
                file_addr_o <= frame_offset(ptr_reg[2], instr_i[6:0]);
                file_indexed_o <= 1'b1;
            end
            else
            begin
                file_addr_o <= ab.eff_addr;
                file_indexed_o <= ab.indexed;
            end
        end
    end

    // ************************************************************
    // Sequencer: long instructions occupy a second cycle
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= EID_IDLE;
            op_reg <= EID_NONE;
        end
        else
        begin
            unique case (state_reg)
                EID_IDLE:
                begin
                    op_reg <= op_next;
                    // Source address already went out on the file port
                    if (is_move(op_next))
                    begin
                        state_reg <= EID_SECOND;
                    end
                    else if (op_next == EID_FRAME_ADD_RET
                        || op_next == EID_FRAME_SUB_RET
                        || op_next == EID_CALL_WORK)
                        state_reg <= EID_FINISH;
                end
                // Second word must carry the F prefix; otherwise abandoned
                EID_SECOND:
                    if (instr_valid_i)
                        state_reg <= EID_IDLE;
                EID_FINISH:
                    state_reg <= EID_IDLE;
                // Unused code of the two-bit state falls back to idle
                default:
                    state_reg <= EID_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Pointer file
    // ************************************************************
    // Pointer updates never touch status flags; there is no flag path here
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < PTR_COUNT; i++)
                ptr_reg[i] <= PTR_RESET;
        end
        else if (state_reg == EID_IDLE)
        begin
            unique case (op_next)
                EID_PTR_ADD, EID_FRAME_ADD_RET:
                    ptr_reg[ptr_index(instr_i[7:6])] <=
                        ptr_reg[ptr_index(instr_i[7:6])]
                        + {6'h00, instr_i[5:0]};
                EID_PTR_SUB, EID_FRAME_SUB_RET:
                    ptr_reg[ptr_index(instr_i[7:6])] <=
                        ptr_reg[ptr_index(instr_i[7:6])]
                        - {6'h00, instr_i[5:0]};
                EID_PUSH_LIT:
                    ptr_reg[2] <= ptr_reg[2] - 12'h001;
                default:
                    ;
            endcase
        end
    end

    // ************************************************************
    // Data write, return and call requests
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_en_o <= 1'b0;
            wr_addr_o <= PTR_RESET;
            wr_data_o <= 8'h00;
            return_req_o <= 1'b0;
            call_req_o <= 1'b0;
            call_low_o <= 8'h00;
        end
        else
        begin
            wr_en_o <= 1'b0;
            return_req_o <= 1'b0;
            call_req_o <= 1'b0;
            if (state_reg == EID_IDLE && op_next == EID_PUSH_LIT)
            begin
                wr_en_o <= 1'b1;
                wr_addr_o <= ptr_reg[2];
                wr_data_o <= instr_i[7:0];
            end
            // Source data read during the second word's cycle is written now
            if (state_reg == EID_SECOND && instr_valid_i
                && instr_i[15:12] == OPC_SECOND_WORD)
            begin
                wr_en_o <= 1'b1;
                wr_data_o <= rd_data_i;
                wr_addr_o <= (op_reg == EID_MOVE_TO_IDX)
                    ? frame_offset(ptr_reg[2], instr_i[6:0])
                    : instr_i[ADDR_W-1:0];
            end
            if (state_reg == EID_FINISH)
            begin
                return_req_o <= (op_reg == EID_FRAME_ADD_RET
                    || op_reg == EID_FRAME_SUB_RET);
                call_req_o <= (op_reg == EID_CALL_WORK);
                call_low_o <= working_reg_i;
            end
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_op_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            ext_op_o <= (state_reg == EID_IDLE) && (op_next != EID_NONE);
            busy_o <= (state_reg == EID_IDLE)
                && (op_next == EID_MOVE_TO_FILE || op_next == EID_MOVE_TO_IDX
                || op_next == EID_FRAME_ADD_RET
                || op_next == EID_FRAME_SUB_RET
                || op_next == EID_CALL_WORK);
        end
    end

    // Pointer outputs registered from the pointer file, one cycle behind it
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ptr0_o <= PTR_RESET;
            ptr1_o <= PTR_RESET;
            stack_frame_pointer_o <= PTR_RESET;
        end
        else
        begin
            ptr0_o <= ptr_reg[0];
            ptr1_o <= ptr_reg[1];
            stack_frame_pointer_o <= ptr_reg[2];
        end
    end
endmodule
`default_nettype wire

// File: eid_checker.sv
// Purpose: Port-level checks on the extended instruction decoder
// Assumes: One clock domain, synchronous active-high reset
// Notes: Checks on pointer outputs want an idle cycle first, since the
// pointer outputs lag the internal pointers by one cycle
`timescale 1ns/1ps
`default_nettype none
module eid_checker
    import eid_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ext_set_enable_fuse_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [DATA_W-1:0] working_reg_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    input wire logic [ADDR_W-1:0] ptr0_o,
    input wire logic [ADDR_W-1:0] stack_frame_pointer_o,
    input wire logic [ADDR_W-1:0] file_addr_o,
    input wire logic file_indexed_o,
    input wire logic wr_en_o,
    input wire logic [ADDR_W-1:0] wr_addr_o,
    input wire logic [DATA_W-1:0] wr_data_o,
    input wire logic return_req_o,
    input wire logic call_req_o,
    input wire logic [DATA_W-1:0] call_low_o,
    input wire logic ext_op_o,
    input wire logic busy_o
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A word is only decoded as a fresh instruction while idle and enabled
    wire logic go = instr_valid_i && !busy_o && ext_set_enable_fuse_i;

    a_fuse_off_quiet: assert property (
        !ext_set_enable_fuse_i && instr_valid_i && !busy_o
        |=> !ext_op_o && !file_indexed_o)
        else $error("extended activity with fuse low");
    a_short_op: assert property (
        go && instr_i[15:9] == 7'b1110100 && instr_i[7:6] != SEL_FRAME_PTR
        |=> ext_op_o && !busy_o)
        else $error("pointer adjust not a one cycle op");
    a_ptr_add_sum: assert property (
        go && instr_i[15:6] == {OPC_PTR_ADD, 2'b00} && !$past(instr_valid_i)
        |-> ##2 ptr0_o == $past(ptr0_o, 2) + 12'($past(instr_i[5:0], 2)))
        else $error("pointer add result wrong");
    a_frame_return: assert property (
        go && instr_i[15:9] == 7'b1110100 && instr_i[7:6] == SEL_FRAME_PTR
        |=> busy_o ##1 return_req_o)
        else $error("frame adjust did not return in two cycles");
    a_call_work: assert property (
        go && instr_i == OPC_CALL_WORK
        |-> ##2 call_req_o && call_low_o == $past(working_reg_i))
        else $error("call through working register wrong");
    a_push_write: assert property (
        go && instr_i[15:8] == OPC_PUSH_LIT && !$past(instr_valid_i)
        |=> wr_en_o && wr_addr_o == $past(stack_frame_pointer_o)
        && wr_data_o == $past(instr_i[7:0]) ##1
        stack_frame_pointer_o == $past(stack_frame_pointer_o, 2) - 12'h001)
        else $error("push literal write or decrement wrong");
    a_move_file: assert property (
        go && instr_i[15:7] == {OPC_MOVE_IDX, 1'b0} ##1 instr_valid_i
        && instr_i[15:12] == OPC_SECOND_WORD
        |=> wr_en_o && wr_addr_o == $past(instr_i[11:0])
        && wr_data_o == $past(rd_data_i))
        else $error("indexed move to file wrong");
    a_offset_addr: assert property (
        go && instr_i[15:8] == 8'h6A && instr_i[7:0] <= OFFSET_LIMIT
        && !$past(instr_valid_i) |=> file_indexed_o && file_addr_o
        == $past(stack_frame_pointer_o) + 12'($past(instr_i[7:0])))
        else $error("frame offset address wrong");
    a_bank_addr: assert property (
        instr_valid_i && !busy_o && instr_i[15:8] == 8'h6B
        |=> !file_indexed_o && file_addr_o
        == {$past(bank_select_reg_i), $past(instr_i[7:0])})
        else $error("banked address wrong");
endmodule

bind eid_decoder eid_checker u_eid_checker (.*);
`default_nettype wire

// File: eid_decoder_tb.sv
// Purpose: Self-checking bench for the extended instruction decoder
// Assumes: Fixed seed; the bench drives every port itself
// Notes: Pulses are counted, so a pulse held too long shows as a miscount
`timescale 1ns/1ps
`default_nettype none
module eid_decoder_tb;
    import eid_pkg::*;
    logic clk_i, sys_rst_i, ext_set_enable_fuse_i, instr_valid_i;
    logic [15:0] instr_i;
    logic [7:0] working_reg_i, rd_data_i, wr_data_o, call_low_o, wd, cl;
    logic [3:0] bank_select_reg_i;
    logic [11:0] ptr0_o, ptr1_o, stack_frame_pointer_o, file_addr_o;
    logic [11:0] wr_addr_o, wa;
    logic file_indexed_o, wr_en_o, return_req_o, call_req_o, ext_op_o, busy_o;
    logic [11:0] p [3];
    int error_cnt = 0, n_checks = 0, n_wr = 0, n_ret = 0, n_call = 0;
    int n_ext = 0, b_wr, b_ret, b_call, b_ext;

    eid_decoder u_eid_decoder (.*);

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Count pulses and keep the last payload of writes and calls
    always @(posedge clk_i)
    begin
        if (!sys_rst_i)
        begin
            n_wr += wr_en_o;
            n_ret += return_req_o;
            n_call += call_req_o;
            n_ext += ext_op_o;
            if (wr_en_o)
                {wa, wd} = {wr_addr_o, wr_data_o};
            if (call_req_o)
                cl = call_low_o;
        end
    end

    // ********************
    // Compare and drive tasks
    // ********************
    task automatic chk_a(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t address %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_d(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int e_wr, e_ret, e_call, e_ext);
        chk_d(8'(n_wr - b_wr), 8'(e_wr));
        chk_d(8'(n_ret - b_ret), 8'(e_ret));
        chk_d(8'(n_call - b_call), 8'(e_call));
        chk_d(8'(n_ext - b_ext), 8'(e_ext));
    endtask

    task automatic chk_ptrs;
        chk_a(ptr0_o, p[0]);
        chk_a(ptr1_o, p[1]);
        chk_a(stack_frame_pointer_o, p[2]);
    endtask

    // Word is held after valid drops, so idle capture sees the same word
    task automatic run(input logic [15:0] w, w2, input bit two);
        {b_wr, b_ret, b_call, b_ext} = {n_wr, n_ret, n_call, n_ext};
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        if (two)
        begin
            @(posedge clk_i);
            instr_i <= w2;
        end
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    function automatic logic [11:0] ea(input logic f, a, input logic [7:0] fld,
        input logic [3:0] b, input logic [11:0] sp);
        if (f && !a && fld <= OFFSET_LIMIT)
            return sp + 12'(fld);
        if (a)
            return {b, fld};
        return (fld < ACCESS_SPLIT) ? {4'h0, fld} : {ACCESS_HIGH_BANK, fld};
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog, far beyond the roughly 600 cycles the tests need
    initial
    begin
        #200_000;
        error_cnt++;
        print_verdict();
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        logic [15:0] w;
        logic [7:0] f;
        logic [6:0] h;
        logic [5:0] k;
        logic a;
        void'($urandom(32'h6F37));
        {sys_rst_i, ext_set_enable_fuse_i, instr_valid_i} = 3'b110;
        {instr_i, working_reg_i, rd_data_i} = '0;
        bank_select_reg_i = 4'h0;
        p = '{PTR_RESET, PTR_RESET, PTR_RESET};
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run(16'h0000, 16'h0000, 1'b0);
        chk_ptrs();
        // Frame pointer still zero: offsets land on the plain access bank
        run(16'h6A2A, 16'h0000, 1'b0);
        chk_a(file_addr_o, 12'h02A);
        for (int i = 0; i < 24; i++)
        begin
            k = (i < 4) ? 6'h3F : 6'($urandom);
            a = i[2];
            run({7'b1110100, a, i[1:0], k}, 16'h0000, 1'b0);
            p[i[1:0] == 2'h3 ? 2 : i % 4] += a ? -12'(k) : 12'(k);
            chk_ptrs();
            chk_n(0, i[1:0] == 2'h3, 0, 1);
        end
        for (int i = 0; i < 2; i++)
        begin
            f = 8'($urandom);
            run({OPC_PUSH_LIT, f}, 16'h0000, 1'b0);
            chk_n(1, 0, 0, 1);
            chk_a(wa, p[2]);
            chk_d(wd, f);
            p[2] -= 12'h001;
            chk_ptrs();
        end
        working_reg_i <= 8'($urandom);
        run(OPC_CALL_WORK, 16'h0000, 1'b0);
        chk_n(0, 0, 1, 1);
        chk_d(cl, working_reg_i);
        // Move to file, move to indexed, then a second word without prefix
        for (int j = 0; j < 3; j++)
        begin
            rd_data_i <= 8'($urandom);
            w = 16'($urandom);
            run({OPC_MOVE_IDX, j[0], w[6:0]},
                {(j == 2) ? 4'h7 : OPC_SECOND_WORD, w[11:0]}, 1'b1);
            chk_n(j < 2, 0, 0, 1);
            chk_a(file_addr_o, p[2] + 12'(w[6:0]));
            if (j < 2)
                chk_a(wa, j ? p[2] + 12'(w[6:0]) : w[11:0]);
            // A refused second word leaves the last write's byte in place
            if (j < 2)
                f = rd_data_i;
            chk_d(wd, f);
        end
        // Operand addressing across instruction families, fuse and limits
        for (int i = 0; i < 60; i++)
        begin
            ext_set_enable_fuse_i <= i[0];
            bank_select_reg_i <= 4'($urandom);
            f = (i < 12) ? 8'h5E + 8'(i >> 2) : 8'($urandom);
            a = (i < 12) ? 1'b0 : 1'($urandom);
            case (i % 3)
                0: h = {6'b001001, 1'($urandom)};
                1: h = {4'b1000, 3'($urandom)};
                default: h = 7'b0110101;
            endcase
            run({h, a, f}, 16'h0000, 1'b0);
            chk_a(file_addr_o, ea(i[0], a, f, bank_select_reg_i, p[2]));
            chk_d(8'(file_indexed_o), 8'(i[0] && !a && f <= 8'h5F));
        end
        ext_set_enable_fuse_i <= 1'b0;
        run({OPC_PTR_ADD, 8'h05}, 16'h0000, 1'b0);
        chk_n(0, 0, 0, 0);
        run({OPC_PUSH_LIT, 8'h5A}, 16'h0000, 1'b0);
        chk_n(0, 0, 0, 0);
        chk_ptrs();
        print_verdict();
    end
endmodule
`default_nettype wire
